// >>> rtl/wsw_watchdog.sv
// Purpose: watchdog timer with sleep entry and wake-up sequencing
// Assumes: core instructions arrive as one-cycle pulses, pins are async
// Notes:   flags here survive the chip reset they request; srst is power-up
//
// Function
// - sleep instruction stops the oscillator and halts execution there.
// - while sleeping, memory, registers and port states stay frozen.
// - sleep instruction clears the watchdog counter; it restarts at zero.
// - entering sleep sets power-down flag, clears watchdog-expired flag.
// - wake on external reset, enabled port A fall, interrupt or overflow.
// - external reset wake performs a full system reset.
// - sleep time-out wakes, sets expired flag, clears only PC and stack.
// - masked port A falling edge wakes; resume after sleep instruction.
// - wake by disabled interrupt or full stack resumes after sleep.
// - wake by enabled interrupt with stack room takes interrupt response.
// - interrupt already flagged before sleep is ignored as wake source.
// - every wake waits 16 core clocks; external reset delay comes first.
// - two-bit select: slow RC, core clock over four, or core clock.
// - period code picks divide 2^8 for 000/001, 2^10..2^15 otherwise.
// - key 000000 enables, 101101 disables, anything else resets device.
// - corrupted key resets the device one to two slow RC cycles later.
// - with watchdog disabled, watchdog instructions do nothing.
// - in sleep a core-clocked watchdog stops counting.
// - overflow in normal running resets device and sets expired flag.
// - counter cleared by bad key, external reset low, clear or sleep.
// - power-down flag cleared by power-up or clear, set by sleep.
// - status writes never alter expired flag or power-down flag.
`timescale 1ns/1ps
module wsw_watchdog
  import wsw_pkg::*;
#(
  parameter int RSTD_COUNT = WSW_RSTD_CYCLES
)
(
  // clock and power-up reset
  input  wire logic         clk,
  input  wire logic         srst,
  // core instruction strobes
  input  wire logic         sleep_exec,
  input  wire logic         watchdog_clear_instruction,
  // special register port
  input  wire wsw_reg_req_t reg_req,
  output logic [7:0]        reg_rdata,
  // pins
  input  wire logic         slow_rc_oscillator,
  input  wire logic         external_clear_pin_n,
  input  wire logic [7:0]   port_a_pins,
  // interrupt controller view
  input  wire logic [3:0]   irq_flag,
  input  wire logic [3:0]   irq_enable,
  input  wire logic         stack_full,
  // core control
  output logic              core_halt,
  output logic              osc_stop,
  output logic              sys_reset_req,
  output logic              resume_valid,
  output wsw_resume_t       resume_kind,
  output logic              watchdog_expired_flag,
  output logic              power_down_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // registers and synchronisers

  logic [7:0]           period_q;
  logic [7:0]           control_q;
  logic [7:0]           wake_mask_q;
  logic [2:0]           rc_sync_q;
  logic [1:0]           ext_sync_q;
  logic [7:0]           pa_meta_q;
  logic [7:0]           pa_sync_q;
  logic [7:0]           pa_prev_q;
  logic [3:0]           irq_armed_q;
  logic [1:0]           div4_q;
  logic [WSW_CNT_W-1:0] cnt_q;
  logic [1:0]           key_cnt_q;
  logic [23:0]          rstd_q;
  logic [4:0]           sst_q;
  wsw_state_t           state_q;
  wsw_resume_t          kind_q;
  logic                 to_q;
  logic                 pdf_q;
  logic                 sys_reset_q;
  logic                 resume_q;
  logic [7:0]           rdata_q;

  logic                 running;
  logic                 sleeping;
  logic                 rc_rise;
  logic                 ext_low;
  logic [1:0]           clk_sel;
  logic [5:0]           key;
  logic                 wd_enabled;
  logic                 key_bad;
  logic                 key_fire;
  logic                 tick;
  logic [WSW_CNT_W-1:0] cnt_inc;
  logic [3:0]           to_bit;
  logic                 timeout;
  logic                 cnt_clear;
  logic                 clr_instr;
  logic                 pa_wake;
  logic [3:0]           irq_new;
  logic                 irq_wake;
  logic                 irq_take;
  logic                 wr_control;

  assign running    = state_q == WSW_RUN;
  assign sleeping   = state_q == WSW_SLEEP;
  assign core_halt  = !running;
  assign osc_stop   = sleeping;
  assign clk_sel    = control_q[WSW_CLKSEL_LSB +: 2];
  assign key        = control_q[WSW_KEY_LSB +: 6];
  assign wd_enabled = key == WSW_KEY_ENABLE;
  assign key_bad    = !wd_enabled && key != WSW_KEY_DISABLE;
  assign rc_rise    = rc_sync_q[1] && !rc_sync_q[2];
  assign ext_low    = !ext_sync_q[1];
  assign clr_instr  = watchdog_clear_instruction && running
                      && wd_enabled;
  assign wr_control = reg_req.wr && running
                      && reg_req.sel == WSW_REG_CONTROL;

  always_ff @(posedge clk)
  begin
    rc_sync_q  <= {rc_sync_q[1:0], slow_rc_oscillator};
    ext_sync_q <= {ext_sync_q[0], external_clear_pin_n};
    pa_meta_q  <= port_a_pins;
    pa_sync_q  <= pa_meta_q;
    pa_prev_q  <= pa_sync_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      period_q    <= WSW_PERIOD_RST;
      control_q   <= WSW_CONTROL_RST;
      wake_mask_q <= WSW_WAKE_RST;
    end
    else if (key_fire)
      control_q <= WSW_CONTROL_RST;
    else if (reg_req.wr && running)
    begin
      unique case (reg_req.sel)
        WSW_REG_PERIOD:  period_q    <= {5'h00, reg_req.wdata[2:0]};
        WSW_REG_CONTROL: control_q   <= reg_req.wdata;
        WSW_REG_WAKE:    wake_mask_q <= reg_req.wdata;
        WSW_REG_STATUS:  ;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      rdata_q <= 8'h00;
    else if (reg_req.rd)
    begin
      unique case (reg_req.sel)
        WSW_REG_PERIOD:  rdata_q <= period_q;
        WSW_REG_CONTROL: rdata_q <= control_q;
        WSW_REG_WAKE:    rdata_q <= wake_mask_q;
        WSW_REG_STATUS:  rdata_q <= {2'h0, to_q, pdf_q, 4'h0};
      endcase
    end
  end

  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // corrupted key: reset on the second slow RC rising edge

  always_ff @(posedge clk)
  begin
    if (srst || !key_bad)
      key_cnt_q <= 2'h0;
    else if (rc_rise)
      key_cnt_q <= key_cnt_q + 2'h1;
  end

  assign key_fire = key_bad && rc_rise
                    && key_cnt_q == 2'(WSW_KEY_RST_EDGES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // watchdog counter

  always_ff @(posedge clk)
  begin
    if (srst)
      div4_q <= 2'h0;
    else if (!sleeping)
      div4_q <= div4_q + 2'h1;
  end

  always_comb
  begin
    unique case (clk_sel)
      WSW_CLK_SLOW: tick = rc_rise;
      WSW_CLK_DIV4: tick = !sleeping && div4_q == 2'h3;
      default:      tick = !sleeping;
    endcase
    tick = tick && wd_enabled && state_q != WSW_RSTD;
  end

  assign to_bit  = period_q[2:0] <= WSW_PER_SHORT ? WSW_PER_BIT_MIN
                   : 4'(period_q[2:0]) + WSW_PER_BIT_MIN;
  assign cnt_inc = cnt_q + 16'h0001;
  assign timeout = tick && !cnt_q[to_bit] && cnt_inc[to_bit];

  assign cnt_clear = (sleep_exec && running) || clr_instr || ext_low
                     || (wr_control && key_bad_wdata(reg_req.wdata))
                     || key_fire || timeout;

  function automatic logic key_bad_wdata(input logic [7:0] d);
    key_bad_wdata = d[WSW_KEY_LSB +: 6] != WSW_KEY_ENABLE
                    && d[WSW_KEY_LSB +: 6] != WSW_KEY_DISABLE;
  endfunction

  always_ff @(posedge clk)
  begin
    if (srst || cnt_clear)
      cnt_q <= 16'h0000;
    else if (tick)
      cnt_q <= cnt_inc;
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags

  always_ff @(posedge clk)
  begin
    if (srst)
      to_q <= 1'b0;
    else if (timeout)
      to_q <= 1'b1;
    else if ((sleep_exec && running) || clr_instr)
      to_q <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      pdf_q <= 1'b0;
    else if (sleep_exec && running)
      pdf_q <= 1'b1;
    else if (clr_instr)
      pdf_q <= 1'b0;
  end

  assign watchdog_expired_flag = to_q;
  assign power_down_flag       = pdf_q;

  ////////////////////////////////////////////////////////////////////////////
  // wake sources

  always_ff @(posedge clk)
  begin
    if (srst)
      irq_armed_q <= 4'h0;
    else if (sleep_exec && running)
      irq_armed_q <= ~irq_flag;
  end

  assign pa_wake  = |(pa_prev_q & ~pa_sync_q & wake_mask_q);
  assign irq_new  = irq_flag & irq_armed_q;
  assign irq_wake = |irq_new;
  assign irq_take = |(irq_new & irq_enable) && !stack_full;

  ////////////////////////////////////////////////////////////////////////////
  // sleep and wake sequencer

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_q <= WSW_RUN;
      kind_q  <= '0;
    end
    else
    begin
      unique case (state_q)
        WSW_RUN:
          if (sleep_exec)
            state_q <= WSW_SLEEP;
        WSW_SLEEP:
          if (ext_low)
          begin
            state_q <= WSW_RSTD;
            kind_q  <= '{1'b1, 1'b0, 1'b0, 1'b0};
          end
          else if (timeout)
          begin
            state_q <= WSW_SST;
            kind_q  <= '{1'b0, 1'b1, 1'b0, 1'b0};
          end
          else if (pa_wake)
          begin
            state_q <= WSW_SST;
            kind_q  <= '{1'b0, 1'b0, 1'b0, 1'b1};
          end
          else if (irq_wake)
          begin
            state_q <= WSW_SST;
            kind_q  <= '{1'b0, 1'b0, irq_take, !irq_take};
          end
        WSW_RSTD:
          if (!ext_low && rstd_q == 24'(RSTD_COUNT - 1))
            state_q <= WSW_SST;
        WSW_SST:
          if (sst_q == 5'(WSW_SST_CYCLES - 1))
            state_q <= WSW_RUN;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst || state_q != WSW_RSTD || ext_low)
      rstd_q <= 24'h000000;
    else
      rstd_q <= rstd_q + 24'h000001;
  end

  always_ff @(posedge clk)
  begin
    if (srst || state_q != WSW_SST)
      sst_q <= 5'h00;
    else
      sst_q <= sst_q + 5'h01;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      resume_q    <= 1'b0;
      sys_reset_q <= 1'b0;
    end
    else
    begin
      resume_q    <= state_q == WSW_SST
                     && sst_q == 5'(WSW_SST_CYCLES - 1);
      sys_reset_q <= (sleeping && ext_low)
                     || (running && timeout)
                     || key_fire;
    end
  end

  assign resume_valid  = resume_q;
  assign resume_kind   = kind_q;
  assign sys_reset_req = sys_reset_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic [4:0] chk_sst_q;

  always_ff @(posedge clk)
  begin
    if (srst || state_q != WSW_SST)
      chk_sst_q <= 5'h00;
    else
      chk_sst_q <= chk_sst_q + 5'h01;
  end

  sleep_flags_a: assert property (@(posedge clk) disable iff (srst)
    sleep_exec && running && !timeout |=> pdf_q && !to_q && cnt_q == '0)
    else $error("sleep entry flags or counter wrong");

  halt_hold_a: assert property (@(posedge clk) disable iff (srst)
    sleep_exec && running |=> core_halt && osc_stop)
    else $error("sleep did not halt core");

  sst_len_a: assert property (@(posedge clk) disable iff (srst)
    $fell(state_q == WSW_SST) |-> $past(chk_sst_q) == 5'h0F && resume_q)
    else $error("start-up wait not 16 cycles");

  status_wr_a: assert property (@(posedge clk) disable iff (srst)
    reg_req.wr && reg_req.sel == WSW_REG_STATUS && !timeout && !sleep_exec
    && !watchdog_clear_instruction |=> $stable(to_q) && $stable(pdf_q))
    else $error("status write changed flags");

  core_stop_a: assert property (@(posedge clk) disable iff (srst)
    sleeping && clk_sel != WSW_CLK_SLOW && !cnt_clear |=> $stable(cnt_q))
    else $error("core-clocked watchdog counted in sleep");

  run_reset_a: assert property (@(posedge clk) disable iff (srst)
    running && timeout |=> sys_reset_req && to_q)
    else $error("overflow did not reset");

  sleep_to_a: assert property (@(posedge clk) disable iff (srst)
    sleeping && timeout && !ext_low |=> state_q == WSW_SST
    && kind_q.pc_sp_clear && to_q && !sys_reset_req)
    else $error("sleep time-out wake wrong");

  clr_noop_a: assert property (@(posedge clk) disable iff (srst)
    watchdog_clear_instruction && !wd_enabled && !timeout && !sleep_exec
    |=> $stable(pdf_q))
    else $error("clear acted while disabled");

  key_reset_a: assert property (@(posedge clk) disable iff (srst)
    key_bad && rc_rise && key_cnt_q == 2'h1 |=> sys_reset_req)
    else $error("bad key did not reset");

  pa_wake_a: assert property (@(posedge clk) disable iff (srst)
    sleeping && pa_wake && !ext_low && !timeout |=> state_q == WSW_SST
    && kind_q.resume_next)
    else $error("port wake missed");

endmodule

// >>> pkg/wsw_pkg.sv
// Purpose: shared constants and types of the watchdog and sleep/wake block
// Assumes: one core clock at 250 MHz, register selects chosen locally
// Notes:   flags bit positions follow the core status register
package wsw_pkg;

  // register selects on the special register port
  localparam logic [1:0] WSW_REG_PERIOD  = 2'h0;
  localparam logic [1:0] WSW_REG_CONTROL = 2'h1;
  localparam logic [1:0] WSW_REG_WAKE    = 2'h2;
  localparam logic [1:0] WSW_REG_STATUS  = 2'h3;

  // reset values
  localparam logic [7:0] WSW_PERIOD_RST  = 8'h07;
  localparam logic [7:0] WSW_CONTROL_RST = 8'h00;
  localparam logic [7:0] WSW_WAKE_RST    = 8'h00;

  // field positions
  localparam int WSW_PERIOD_LSB = 0;
  localparam int WSW_CLKSEL_LSB = 6;
  localparam int WSW_KEY_LSB    = 0;
  localparam int WSW_TO_BIT     = 5;
  localparam int WSW_PDF_BIT    = 4;

  // field codes
  localparam logic [5:0] WSW_KEY_ENABLE  = 6'h00;
  localparam logic [5:0] WSW_KEY_DISABLE = 6'h2D;
  localparam logic [1:0] WSW_CLK_SLOW    = 2'h0;
  localparam logic [1:0] WSW_CLK_DIV4    = 2'h1;
  localparam logic [2:0] WSW_PER_SHORT   = 3'h1;
  localparam logic [3:0] WSW_PER_BIT_MIN = 4'h8;

  // timing
  localparam int WSW_CLK_PERIOD_NS = 4;
  localparam int WSW_SST_CYCLES    = 16;
  localparam int WSW_RSTD_NS       = 50000000;
  localparam int WSW_RSTD_CYCLES   =
    (WSW_RSTD_NS + WSW_CLK_PERIOD_NS - 1) / WSW_CLK_PERIOD_NS;
  localparam int WSW_KEY_RST_EDGES = 2;
  localparam int WSW_CNT_W         = 16;

  typedef enum logic [1:0] {
    WSW_RUN   = 2'h0,
    WSW_SLEEP = 2'h1,
    WSW_SST   = 2'h3,
    WSW_RSTD  = 2'h2
  } wsw_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [1:0] sel;
    logic [7:0] wdata;
  } wsw_reg_req_t;

  typedef struct packed {
    logic full_reset;
    logic pc_sp_clear;
    logic take_irq;
    logic resume_next;
  } wsw_resume_t;

endpackage

// >>> test/wsw_watchdog_tb.sv
// Purpose: self-checking bench for the watchdog and sleep/wake block
// Assumes: reset delay shortened to 8 cycles, slow rc runs at clk/8
// Notes:   inputs change on the falling clock edge
`timescale 1ns/1ps
module wsw_watchdog_tb;
  import wsw_pkg::*;
  localparam int RSTD_SIM = 8;
  logic         clk;
  logic         srst;
  logic         sleep_exec;
  logic         clr_instr;
  wsw_reg_req_t reg_req;
  logic [7:0]   reg_rdata;
  logic         slow_rc = 1'b0;
  logic [1:0]   rc_div  = 2'h0;
  logic         ext_n;
  logic [7:0]   port_a;
  logic [3:0]   irq_flag;
  logic [3:0]   irq_enable;
  logic         stack_full;
  logic         core_halt;
  logic         osc_stop;
  logic         sys_reset_req;
  logic         resume_valid;
  wsw_resume_t  resume_kind;
  logic         to_flag;
  logic         pd_flag;
  int           errors;
  int           n_compared;
  logic [7:0]   rv;
  int           n;
  int           m;

  wsw_watchdog #(.RSTD_COUNT(RSTD_SIM)) wsw_watchdog_inst (
    .clk                        (clk),
    .srst                       (srst),
    .sleep_exec                 (sleep_exec),
    .watchdog_clear_instruction (clr_instr),
    .reg_req                    (reg_req),
    .reg_rdata                  (reg_rdata),
    .slow_rc_oscillator         (slow_rc),
    .external_clear_pin_n       (ext_n),
    .port_a_pins                (port_a),
    .irq_flag                   (irq_flag),
    .irq_enable                 (irq_enable),
    .stack_full                 (stack_full),
    .core_halt                  (core_halt),
    .osc_stop                   (osc_stop),
    .sys_reset_req              (sys_reset_req),
    .resume_valid               (resume_valid),
    .resume_kind                (resume_kind),
    .watchdog_expired_flag      (to_flag),
    .power_down_flag            (pd_flag)
  );

  ////////////////////////////////////////////////////////////////////////
  // clocks
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(negedge clk)
  begin
    rc_div <= rc_div + 2'h1;
    if (rc_div == 2'h3)
      slow_rc <= ~slow_rc;
  end

  ////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic check(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask

  task automatic tally_and_finish;
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask

  task automatic do_reset;
    srst = 1'b1;
    cyc(8);
    srst = 1'b0;
  endtask

  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    @(negedge clk);
    reg_req = '{1'b1, 1'b0, s, d};
    @(negedge clk);
    reg_req = '0;
  endtask

  task automatic rd(input logic [1:0] s, output logic [7:0] d);
    @(negedge clk);
    reg_req = '{1'b0, 1'b1, s, 8'h00};
    @(negedge clk);
    reg_req = '0;
    d = reg_rdata;
  endtask

  task automatic pulse(input int w);
    @(negedge clk);
    if (w == 0) sleep_exec = 1'b1;
    else clr_instr = 1'b1;
    @(negedge clk);
    sleep_exec = 1'b0;
    clr_instr = 1'b0;
  endtask

  // w: 0 reset request, 1 resume, 2 oscillator restarted
  task automatic wait_ev(input int w, input int lim, output int k);
    k = 0;
    while (k < lim && !((w == 0 && sys_reset_req === 1'b1) ||
           (w == 1 && resume_valid === 1'b1) ||
           (w == 2 && osc_stop === 1'b0)))
    begin
      @(negedge clk);
      k++;
    end
  endtask

  task automatic port_wake(output int k);
    int j;
    port_a = 8'hFE;
    wait_ev(2, 20, j);
    wait_ev(1, 40, k);
    port_a = 8'hFF;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset_values;
    rd(WSW_REG_PERIOD, rv);
    check(rv === WSW_PERIOD_RST, "period reset value");
    rd(WSW_REG_CONTROL, rv);
    check(rv === WSW_CONTROL_RST, "control reset value");
    rd(WSW_REG_WAKE, rv);
    check(rv === WSW_WAKE_RST, "wake mask reset value");
    rd(WSW_REG_STATUS, rv);
    check(rv === 8'h00, "flags after power-up");
    wr(WSW_REG_PERIOD, 8'hFF);
    rd(WSW_REG_PERIOD, rv);
    check(rv === 8'h07, "period upper bits read zero");
  endtask

  task automatic t_port_wake;
    wr(WSW_REG_WAKE, 8'h01);
    pulse(0);
    check(core_halt === 1'b1 && osc_stop === 1'b1, "sleep halt");
    check(pd_flag === 1'b1 && to_flag === 1'b0, "flags on sleep");
    wr(WSW_REG_PERIOD, 8'h03);
    wr(WSW_REG_STATUS, 8'h00);
    port_wake(m);
    check(m == WSW_SST_CYCLES, "start-up wait length");
    check(resume_kind === 4'h1, "port wake resumes next");
    rd(WSW_REG_PERIOD, rv);
    check(rv === 8'h07, "register held in sleep");
    wr(WSW_REG_STATUS, 8'h00);
    rd(WSW_REG_STATUS, rv);
    check(rv === 8'h10, "status write keeps flags");
  endtask

  task automatic t_disable_clear;
    wr(WSW_REG_CONTROL, 8'h2D);
    pulse(1);
    check(pd_flag === 1'b1, "clear ignored when disabled");
    wr(WSW_REG_CONTROL, 8'h00);
    pulse(1);
    check(pd_flag === 1'b0, "clear drops power-down flag");
  endtask

  task automatic t_irq;
    irq_enable = 4'hF;
    irq_flag = 4'h1;
    pulse(0);
    cyc(40);
    check(osc_stop === 1'b1, "old request ignored");
    irq_flag = 4'h3;
    wait_ev(1, 60, n);
    check(resume_kind === 4'h2, "enabled irq serviced");
    for (int k = 0; k < 2; k++)
    begin
      irq_flag = 4'h0;
      stack_full = (k == 0);
      irq_enable = (k == 0) ? 4'hF : 4'h0;
      pulse(0);
      irq_flag = 4'h4;
      wait_ev(1, 60, n);
      check(resume_kind === 4'h1, "deferred irq resumes next");
    end
    irq_flag = 4'h0;
    stack_full = 1'b0;
  endtask

  task automatic t_core_clock;
    wr(WSW_REG_CONTROL, 8'h80);
    wr(WSW_REG_PERIOD, 8'h00);
    pulse(0);
    cyc(600);
    check(osc_stop === 1'b1, "core-clocked watchdog halts");
    port_wake(m);
    pulse(1);
    wait_ev(0, 400, n);
    check(n >= 250 && n <= 265, "core clock 2^8 timeout");
    cyc(1);
    check(to_flag === 1'b1, "running timeout flag");
    do_reset;
    wr(WSW_REG_CONTROL, 8'h40);
    wr(WSW_REG_PERIOD, 8'h00);
    pulse(1);
    wait_ev(0, 1300, n);
    check(n >= 1015 && n <= 1040, "divided clock timeout");
    do_reset;
  endtask

  task automatic t_sleep_timeout;
    wr(WSW_REG_PERIOD, 8'h00);
    for (int k = 0; k < 2; k++)
    begin
      pulse(0);
      check(to_flag === 1'b0, "sleep clears expired flag");
      wait_ev(2, 2600, n);
      check(n >= 1900 && n <= 2200, "sleep timeout span");
      wait_ev(1, 40, m);
      check(resume_kind === 4'h4, "timeout clears pc only");
      check(to_flag === 1'b1 && pd_flag === 1'b1, "timeout flags");
    end
    do_reset;
  endtask

  task automatic t_bad_key;
    wr(WSW_REG_CONTROL, 8'h05);
    wait_ev(0, 40, n);
    check(n >= 4 && n <= 30, "bad key reset delay");
    rd(WSW_REG_CONTROL, rv);
    check(rv === 8'h00, "control back to default");
    do_reset;
  endtask

  task automatic t_ext_wake;
    pulse(0);
    ext_n = 1'b0;
    wait_ev(0, 10, n);
    check(sys_reset_req === 1'b1, "external reset wake");
    cyc(4);
    ext_n = 1'b1;
    wait_ev(1, 60, n);
    check(n >= 24 && n <= 29, "reset delay then start-up");
    check(resume_kind === 4'h8, "full reset resume");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial
  begin
    errors = 0;
    n_compared = 0;
    srst = 1'b1;
    sleep_exec = 1'b0;
    clr_instr = 1'b0;
    reg_req = '0;
    ext_n = 1'b1;
    port_a = 8'hFF;
    irq_flag = 4'h0;
    irq_enable = 4'h0;
    stack_full = 1'b0;
    do_reset;
    t_reset_values;
    t_port_wake;
    t_disable_clear;
    t_irq;
    t_core_clock;
    t_sleep_timeout;
    t_bad_key;
    t_ext_wake;
    tally_and_finish;
  end

  initial
  begin
    #(40000 * WSW_CLK_PERIOD_NS);
    errors++;
    $display("MISMATCH at %0t: run did not complete", $time);
    tally_and_finish;
  end
endmodule
